// ===== shared/stp_defines.svh
// Register map, key values, field positions and reset values of the test port.
`ifndef STP_DEFINES_SVH
`define STP_DEFINES_SVH

// Byte addresses of the six registers.
`define STP_ADDR_KEY_FIRST   32'hFFFF_0880
`define STP_ADDR_CONTROL     32'hFFFF_0884
`define STP_ADDR_KEY_SECOND  32'hFFFF_0888
`define STP_ADDR_BYTES_12    32'hFFFF_088C
`define STP_ADDR_BYTES_34    32'hFFFF_0890
`define STP_ADDR_BYTES_56    32'hFFFF_0894

// Unlock key values.
`define STP_KEY_FIRST_VAL    16'h0007
`define STP_KEY_SECOND_VAL   16'h00B9

// Control register fields.
`define STP_CTL_EN           0
`define STP_CTL_SRST         1
`define STP_CTL_CNT_LO       2
`define STP_CTL_CNT_HI       4
`define STP_CTL_ST_LO        5
`define STP_CTL_ST_HI        8

// Byte count codes.
`define STP_CNT_MAX          3'h5
`define STP_CNT_THREE        3'h2
`define STP_CNT_FOUR         3'h3

// Reset values.
`define STP_CTL_RESET        16'h0000
`define STP_DAT_RESET        16'h0000
`define STP_RD_ZERO          32'h0000_0000

// Frame layout: start, eight data, parity, two stops.
`define STP_FRAME_LAST       4'hB
`define STP_STATE_BIAS       4'h1

`endif

// ===== shared/stp_pkg.sv
// Types shared by the serial test port design.
package stp_pkg;

	// Progress through the key-protected control write.
	typedef enum logic [1:0] {
		KEY_IDLE,
		KEY_OPEN,
		KEY_HELD
	} stp_key_t;

	// Transmit sequencer states.
	typedef enum logic [1:0] {
		TX_OFF,
		TX_ARMED,
		TX_SEND,
		TX_NEXT
	} stp_tx_t;

endpackage

// ===== core/stp_frame_tx.sv
// Serialiser that sends one byte as a twelve-bit framed packet.
`include "stp_defines.svh"

module stp_frame_tx
	import stp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       load,
	input  wire logic [7:0] byteIn,
	input  wire logic       tick,
	input  wire logic       abort,
	output logic            serOut,
	output logic            done
);

	logic [11:0] shift_r;
	logic [3:0]  bitCnt_r;
	logic        busy_r;
	logic        out_r;
	logic        done_r;
	logic [11:0] frameWord;
	logic        lastBit;

	// Stops, even parity, data LSB first, start bit in bit zero.
	assign frameWord = {2'b11, ^byteIn, byteIn, 1'b0};
	assign lastBit   = (bitCnt_r == `STP_FRAME_LAST);
	assign serOut    = out_r;
	assign done      = done_r;

	// Each timer overflow moves the line on by exactly one bit.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_r  <= 12'h0FFF;
			bitCnt_r <= 4'h0;
			busy_r   <= 1'b0;
			out_r    <= 1'b1;
			done_r   <= 1'b0;
		end else if (ce) begin
			done_r <= 1'b0;
			if (abort) begin
				busy_r <= 1'b0;
				out_r  <= 1'b1;
			end else if (load) begin
				shift_r  <= frameWord;
				bitCnt_r <= 4'h0;
				busy_r   <= 1'b1;
				out_r    <= frameWord[0];
			end else if (busy_r && tick) begin
				if (lastBit) begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
					out_r  <= 1'b1;
				end else begin
					shift_r  <= {1'b1, shift_r[11:1]};
					bitCnt_r <= bitCnt_r + 4'h1;
					out_r    <= shift_r[1];
				end
			end
		end
	end

endmodule // stp_frame_tx

// ===== core/stp_serial_test_port.sv
// Transmit-only serial test port with an APB register file whose control register is key-protected.
`include "stp_defines.svh"

module stp_serial_test_port
	import stp_pkg::*;
#(
	parameter int ADDR_W = 32
)(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              bitTick,
	output logic                   serialOut
);

	////////////////////////////////////////////////////////////////////////
	// Declarations.

	logic        pready_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;

	stp_key_t    keyState_r;
	stp_key_t    keyState_nxt;
	logic [15:0] pending_r;

	logic        ctrlEn_r;
	logic [2:0]  ctrlCnt_r;

	logic [15:0] datReg_r [0:2];
	logic [2:0]  seen_r;
	logic [2:0]  seen_nxt;

	stp_tx_t     txState_r;
	stp_tx_t     txState_nxt;
	logic [2:0]  byteIdx_r;
	logic [2:0]  byteIdx_nxt;

	logic        accFirst;
	logic        accDone;
	logic        wrDone;
	logic        selKey0;
	logic        selCtl;
	logic        selKey1;
	logic [2:0]  selDat;
	logic        hit;
	logic        key0Ok;
	logic        key1Ok;
	logic        ctlWrite;
	logic        commit;
	logic        softRst;
	logic [2:0]  newCnt;
	logic [2:0]  needMask;
	logic        dataReady;
	logic        sending;
	logic [3:0]  stateField;
	logic [15:0] ctrlView;
	logic [15:0] rdWord;
	logic [15:0] pairWord;
	logic [7:0]  curByte;
	logic        lastByte;
	logic        frameLoad;
	logic        frameDone;
	logic        frameAbort;
	logic        seenClear;
	logic [2:0]  seenSet;

	////////////////////////////////////////////////////////////////////////
	// Bus decode.

	// Every transfer gets one wait state so read data comes from a flop.
	assign accFirst = psel && penable && !pready_r;
	assign accDone  = psel && penable && pready_r;
	assign wrDone   = accDone && pwrite;

	// Full-address decode of the six words.
	assign selKey0  = (paddr == ADDR_W'(`STP_ADDR_KEY_FIRST));
	assign selCtl   = (paddr == ADDR_W'(`STP_ADDR_CONTROL));
	assign selKey1  = (paddr == ADDR_W'(`STP_ADDR_KEY_SECOND));
	assign selDat[0] = (paddr == ADDR_W'(`STP_ADDR_BYTES_12));
	assign selDat[1] = (paddr == ADDR_W'(`STP_ADDR_BYTES_34));
	assign selDat[2] = (paddr == ADDR_W'(`STP_ADDR_BYTES_56));
	assign hit      = selKey0 || selCtl || selKey1 || (|selDat);

	////////////////////////////////////////////////////////////////////////
	// Key sequence.

	// Key compares look only at the low half; upper bits are don't-care.
	assign key0Ok   = wrDone && selKey0
		&& (pwdata[15:0] == `STP_KEY_FIRST_VAL);
	assign key1Ok   = wrDone && selKey1
		&& (pwdata[15:0] == `STP_KEY_SECOND_VAL);
	assign ctlWrite = wrDone && selCtl;
	assign commit   = (keyState_r == KEY_HELD) && key1Ok;
	assign softRst  = commit && pending_r[`STP_CTL_SRST];

	// Any completed access, read or write, moves the sequence on, so a
	// stray access between the three steps cancels the unlock.
	always_comb begin
		keyState_nxt = keyState_r;
		if (accDone) begin
			case (keyState_r)
				KEY_IDLE: begin
					keyState_nxt = key0Ok ? KEY_OPEN : KEY_IDLE;
				end
				KEY_OPEN: begin
					if (ctlWrite) begin
						keyState_nxt = KEY_HELD;
					end else begin
						keyState_nxt = key0Ok ? KEY_OPEN : KEY_IDLE;
					end
				end
				KEY_HELD: begin
					keyState_nxt = key0Ok ? KEY_OPEN : KEY_IDLE;
				end
				default: begin
					keyState_nxt = KEY_IDLE;
				end
			endcase
		end
	end

	// Sequence state and the control value waiting for the second key.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			keyState_r <= KEY_IDLE;
			pending_r  <= `STP_CTL_RESET;
		end else if (ce) begin
			keyState_r <= keyState_nxt;
			if (ctlWrite && keyState_r == KEY_OPEN) begin
				pending_r <= pwdata[15:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control register.

	// Codes above six bytes are clamped to six rather than left undefined.
	assign newCnt = (pending_r[`STP_CTL_CNT_HI:`STP_CTL_CNT_LO] > `STP_CNT_MAX)
		? `STP_CNT_MAX
		: pending_r[`STP_CTL_CNT_HI:`STP_CTL_CNT_LO];

	// The stored fields change only when the second key lands.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrlEn_r  <= 1'b0;
			ctrlCnt_r <= 3'h0;
		end else if (ce) begin
			if (softRst) begin
				ctrlEn_r  <= 1'b0;
				ctrlCnt_r <= 3'h0;
			end else if (commit) begin
				ctrlEn_r  <= pending_r[`STP_CTL_EN];
				ctrlCnt_r <= newCnt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data registers and the written-since-enable marks.

	// Byte pairs needed: one register up to two bytes, two up to four.
	assign needMask = (ctrlCnt_r > `STP_CNT_FOUR) ? 3'b111
		: (ctrlCnt_r >= `STP_CNT_THREE) ? 3'b011
		: 3'b001;
	assign dataReady = ((seen_r & needMask) == needMask);

	// A write in the same cycle as the clear is kept: set wins.
	assign seenSet  = wrDone ? selDat : 3'b000;
	assign seen_nxt = (seen_r & ~(seenClear ? 3'b111 : 3'b000)) | seenSet;

	// Storage for the six bytes, written as whole sixteen-bit words.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 3; i++) begin
				datReg_r[i] <= `STP_DAT_RESET;
			end
			seen_r <= 3'b000;
		end else if (ce) begin
			for (int i = 0; i < 3; i++) begin
				if (seenSet[i]) begin
					datReg_r[i] <= pwdata[15:0];
				end
			end
			seen_r <= seen_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit sequencer.

	// Byte N sits in register N/2, low half for even N.
	assign pairWord = datReg_r[byteIdx_r[2:1]];
	assign curByte  = byteIdx_r[0] ? pairWord[15:8]
		: pairWord[7:0];
	assign lastByte = (byteIdx_r == ctrlCnt_r);
	assign sending  = (txState_r == TX_SEND) || (txState_r == TX_NEXT);
	assign frameAbort = softRst || !ctrlEn_r;

	// Marks clear on every control commit and after the last byte, so a
	// new transfer needs fresh data writes.
	assign seenClear = commit || (txState_r == TX_SEND && frameDone && lastByte);

	always_comb begin
		txState_nxt = txState_r;
		byteIdx_nxt = byteIdx_r;
		frameLoad   = 1'b0;
		case (txState_r)
			TX_OFF: begin
				byteIdx_nxt = 3'h0;
				if (ctrlEn_r) begin
					txState_nxt = TX_ARMED;
				end
			end
			TX_ARMED: begin
				byteIdx_nxt = 3'h0;
				if (!ctrlEn_r) begin
					txState_nxt = TX_OFF;
				end else if (dataReady) begin
					frameLoad   = 1'b1;
					txState_nxt = TX_SEND;
				end
			end
			TX_SEND: begin
				if (!ctrlEn_r) begin
					txState_nxt = TX_OFF;
				end else if (frameDone && lastByte) begin
					txState_nxt = TX_ARMED;
				end else if (frameDone) begin
					byteIdx_nxt = byteIdx_r + 3'h1;
					txState_nxt = TX_NEXT;
				end
			end
			TX_NEXT: begin
				if (!ctrlEn_r) begin
					txState_nxt = TX_OFF;
				end else begin
					frameLoad   = 1'b1;
					txState_nxt = TX_SEND;
				end
			end
			default: begin
				txState_nxt = TX_OFF;
			end
		endcase
	end

	// Soft reset drops any transfer in flight at once.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			txState_r <= TX_OFF;
			byteIdx_r <= 3'h0;
		end else if (ce) begin
			txState_r <= softRst ? TX_OFF : txState_nxt;
			byteIdx_r <= softRst ? 3'h0 : byteIdx_nxt;
		end
	end

	// Packet serialiser; its output flop drives the pin directly.
	stp_frame_tx u_frame (
		.clk    (clk),
		.rst_n  (rst_n),
		.ce     (ce),
		.load   (frameLoad),
		.byteIn (curByte),
		.tick   (bitTick),
		.abort  (frameAbort),
		.serOut (serialOut),
		.done   (frameDone)
	);

	////////////////////////////////////////////////////////////////////////
	// Read path.

	// State shows byte number plus one, so it is never zero while busy.
	assign stateField = sending
		? (4'(byteIdx_r) + `STP_STATE_BIAS)
		: 4'h0;

	// Reset bit and reserved bits always read as zero.
	assign ctrlView = {7'h00, stateField, ctrlCnt_r,
		1'b0, ctrlEn_r};

	// Key registers are write-only and read as zero.
	assign rdWord = selCtl    ? ctrlView
		: selDat[0] ? datReg_r[0]
		: selDat[1] ? datReg_r[1]
		: selDat[2] ? datReg_r[2]
		: 16'h0000;

	// Answer registered in the first access cycle, so pready and the data
	// rise together one cycle later.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready_r  <= 1'b0;
			prdata_r  <= `STP_RD_ZERO;
			pslverr_r <= 1'b0;
		end else if (ce) begin
			pready_r  <= accFirst;
			pslverr_r <= accFirst && !hit;
			if (accFirst) begin
				prdata_r <= pwrite ? `STP_RD_ZERO : {16'h0000, rdWord};
			end
		end
	end

	assign pready  = pready_r;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;

endmodule // stp_serial_test_port

// ===== testbench/stp_serial_test_port_monitor.sv
// Concurrent checks on the APB and serial line ports of the test port.
`include "stp_defines.svh"

module stp_serial_test_port_monitor #(
	parameter int ADDR_W = 32
)(
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              ce,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              bitTick,
	input wire logic              serialOut
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       inFrame_r;
	logic [3:0] cnt_r;
	logic [8:0] bits_r;
	wire        isMapped;
	wire        isKey;

	////////////////////////////////////////
	// Address decode mirrors the six mapped words.
	assign isKey = paddr == `STP_ADDR_KEY_FIRST || paddr == `STP_ADDR_KEY_SECOND;
	assign isMapped = isKey || paddr == `STP_ADDR_CONTROL || paddr == `STP_ADDR_BYTES_12
		|| paddr == `STP_ADDR_BYTES_34 || paddr == `STP_ADDR_BYTES_56;

	// Frame tracker; a tick on the detecting edge already ends the start bit.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			inFrame_r <= 1'b0;
			cnt_r <= 4'h0;
			bits_r <= 9'h000;
		end else if (!inFrame_r && !serialOut) begin
			inFrame_r <= 1'b1;
			cnt_r <= bitTick ? 4'h1 : 4'h0;
		end else if (inFrame_r && bitTick) begin
			if (cnt_r < 4'h9) bits_r[cnt_r] <= serialOut;
			cnt_r <= cnt_r + 4'h1;
			inFrame_r <= cnt_r != 4'hB;
		end
	end

	////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// First access cycle of a transfer.
	sequence s_access_start;
		ce && psel && penable && !$past(penable);
	endsequence

	// One wait cycle, then the answer, which the slave never skips.
	sequence s_wait_then_ready;
		!pready ##1 pready;
	endsequence

	a_ready_wait: assert property (s_access_start |-> s_wait_then_ready)
		else $error("pready not after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_decode: assert property (pready |-> pslverr == !isMapped)
		else $error("pslverr does not match decode");
	a_rdata_upper: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	a_key_zero: assert property (
		pready && !pwrite && isKey |-> prdata == `STP_RD_ZERO)
		else $error("key register read not zero");
	a_start_low: assert property (inFrame_r && cnt_r == 4'h0 |-> !serialOut)
		else $error("start bit left before tick");
	a_bit_steady: assert property (
		inFrame_r && $past(inFrame_r) && !$past(bitTick) |-> $stable(serialOut))
		else $error("line moved without tick");
	a_parity_even: assert property (
		inFrame_r && bitTick && cnt_r == 4'h9 |-> serialOut == ^bits_r[8:1])
		else $error("parity bit not even");
	a_stop_high: assert property (
		inFrame_r && bitTick && cnt_r > 4'h9 |-> serialOut)
		else $error("stop bit low");
endmodule // stp_serial_test_port_monitor

bind stp_serial_test_port stp_serial_test_port_monitor #(.ADDR_W(ADDR_W))
	u_stp_serial_test_port_monitor (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .bitTick(bitTick), .serialOut(serialOut));

// ===== testbench/stp_rx_model.sv
// Receiving test equipment: samples each bit at the tick that ends it.
module stp_rx_model (
	input wire logic  clk,
	input wire logic  rst_n,
	input wire logic  bitTick,
	input wire logic  serialOut,
	output logic       rxValid,
	output logic [7:0] rxByte,
	output logic       rxOk
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        busy_r;
	logic [3:0]  cnt_r;
	logic [10:0] bits_r;

	// A low idle line opens a frame; twelve ticks close it with a verdict.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			cnt_r <= 4'h0;
			bits_r <= 11'h000;
			rxValid <= 1'b0;
			rxByte <= 8'h00;
			rxOk <= 1'b0;
		end else begin
			rxValid <= 1'b0;
			if (!busy_r && !serialOut) begin
				busy_r <= 1'b1;
				cnt_r <= bitTick ? 4'h1 : 4'h0;
				bits_r[0] <= 1'b0;
			end else if (busy_r && bitTick) begin
				if (cnt_r < 4'hB) bits_r[cnt_r] <= serialOut;
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r == 4'hB) begin
					busy_r <= 1'b0;
					rxValid <= 1'b1;
					rxByte <= bits_r[8:1];
					rxOk <= !bits_r[0] && bits_r[9] == ^bits_r[8:1] && bits_r[10] && serialOut;
				end
			end
		end
	end
endmodule // stp_rx_model

// ===== testbench/stp_serial_test_port_test.sv
// Self-checking bench for the serial test port.
`include "stp_defines.svh"
`define CHK(nm, ex, ac) begin samplesChecked++; if ((ac) !== (ex)) begin nMismatch++; \
	$display("MISMATCH %s exp %h got %h", nm, ex, ac); end end

module stp_serial_test_port_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic        bitTick = 1'b0;
	logic [31:0] paddr = 32'h0000_0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, serialOut, rxValid, rxOk, err;
	logic [7:0]  rxByte;
	logic [8:0]  rxQ[$];
	logic [47:0] dw;
	logic [15:0] ctl;
	int          nMismatch = 0;
	int          samplesChecked = 0;
	int          gap = 0;
	logic [31:0] addrs[7] = '{`STP_ADDR_KEY_FIRST, `STP_ADDR_CONTROL, `STP_ADDR_KEY_SECOND,
		`STP_ADDR_BYTES_12, `STP_ADDR_BYTES_34, `STP_ADDR_BYTES_56, 32'hFFFF_0898};
	logic [15:0] k0t[3] = '{16'h0006, 16'h0007, 16'h0007};
	logic [15:0] k1t[3] = '{16'h00B9, 16'h00B9, 16'h00B8};

	stp_serial_test_port #(.ADDR_W(32)) u_stp_serial_test_port (.clk(clk), .rst_n(rst_n),
		.ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bitTick(bitTick), .serialOut(serialOut));
	stp_rx_model u_stp_rx_model (.clk(clk), .rst_n(rst_n), .bitTick(bitTick),
		.serialOut(serialOut), .rxValid(rxValid), .rxByte(rxByte), .rxOk(rxOk));

	////////////////////////////////////////
	initial forever #12.5 clk = ~clk;

	// Overflow pulses three to six cycles apart, so the frame gap is exercised.
	always @(posedge clk) begin
		gap <= (gap == 0) ? $urandom_range(5, 2) : gap - 1;
		bitTick <= (gap == 0);
	end

	// Received bytes are queued with their framing verdict.
	always @(posedge clk) if (rxValid === 1'b1) rxQ.push_back({rxOk, rxByte});

	////////////////////////////////////////
	function automatic logic [7:0] expByte(input logic [47:0] w, input int i);
		return w[8*i +: 8];
	endfunction

	task automatic conclude();
		$display("Counts: %0d mismatches in %0d checks", nMismatch, samplesChecked);
		if (nMismatch == 0 && samplesChecked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// One APB transfer; the request holds until pready is seen at an edge.
	task automatic apb(input logic [31:0] a, input logic wr, input logic [15:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, wd};
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 20) begin
			nMismatch++;
			conclude();
		end
	endtask

	// Key, control, optional stray read, key.
	task automatic commit(input logic [15:0] k0, c, k1, input logic mid);
		apb(`STP_ADDR_KEY_FIRST, 1'b1, k0);
		apb(`STP_ADDR_CONTROL, 1'b1, c);
		if (mid) apb(`STP_ADDR_BYTES_12, 1'b0, 16'h0000);
		apb(`STP_ADDR_KEY_SECOND, 1'b1, k1);
	endtask

	task automatic waitRx(input int n);
		int t;
		t = 0;
		while (rxQ.size() < n && t < 3000) begin
			@(posedge clk);
			t++;
		end
		if (t >= 3000) begin
			nMismatch++;
			conclude();
		end
	endtask

	////////////////////////////////////////
	initial begin
		void'($urandom(32'h6e9f_b8b0));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (addrs[i]) begin
			apb(addrs[i], 1'b0, 16'h0000);
			`CHK("reset read", `STP_RD_ZERO, rd);
			`CHK("slverr", (i == 6), err);
		end
		$display("test reset values done");
		// A bare control write, then bad first key, stray read, bad second key.
		apb(`STP_ADDR_CONTROL, 1'b1, 16'h0001);
		apb(`STP_ADDR_KEY_SECOND, 1'b1, `STP_KEY_SECOND_VAL);
		for (int i = 0; i < 4; i++) begin
			if (i > 0) commit(k0t[i-1], 16'h0001, k1t[i-1], i == 2);
			apb(`STP_ADDR_CONTROL, 1'b0, 16'h0000);
			`CHK("locked control", `STP_RD_ZERO, rd);
		end
		$display("test key sequence done");
		// Every byte count: hold-off until data, order, framing, readback.
		for (int c = 0; c < 6; c++) begin
			ctl = 16'h0001 | (16'(c) << 2);
			dw[31:0] = $urandom;
			dw[47:32] = 16'($urandom);
			if (c == 0) dw[7:0] = 8'h80;
			rxQ.delete();
			commit(`STP_KEY_FIRST_VAL, ctl, `STP_KEY_SECOND_VAL, 1'b0);
			for (int k = 0; k <= c / 2; k++) begin
				repeat (60) @(posedge clk);
				`CHK("held off", 0, rxQ.size());
				`CHK("idle line", 1'b1, serialOut);
				apb(`STP_ADDR_BYTES_12 + 32'(4 * k), 1'b1, dw[16*k +: 16]);
			end
			apb(`STP_ADDR_CONTROL, 1'b0, 16'h0000);
			`CHK("busy state", 1'b1, |rd[8:5]);
			`CHK("busy readback", 1'b1, rd[15:0] !== ctl);
			waitRx(c + 1);
			for (int i = 0; i <= c; i++) begin
				`CHK("rx byte", {1'b1, expByte(dw, i)}, rxQ[i]);
			end
			// Long enough for a spurious extra packet to arrive in full.
			repeat (100) @(posedge clk);
			`CHK("rx count", c + 1, rxQ.size());
			apb(`STP_ADDR_CONTROL, 1'b0, 16'h0000);
			`CHK("done readback", {16'h0000, ctl}, rd);
			$display("test count %0d done", c);
		end
		// A disabled port sends nothing; soft reset clears control.
		rxQ.delete();
		commit(`STP_KEY_FIRST_VAL, 16'h0014, `STP_KEY_SECOND_VAL, 1'b0);
		apb(`STP_ADDR_BYTES_12, 1'b1, 16'h5A5A);
		repeat (100) @(posedge clk);
		`CHK("disabled quiet", 0, rxQ.size());
		apb(`STP_ADDR_BYTES_12, 1'b0, 16'h0000);
		`CHK("data readback", 32'h0000_5A5A, rd);
		commit(`STP_KEY_FIRST_VAL, 16'h0017, `STP_KEY_SECOND_VAL, 1'b0);
		apb(`STP_ADDR_CONTROL, 1'b0, 16'h0000);
		`CHK("soft reset", `STP_RD_ZERO, rd);
		$display("test disable and soft reset done");
		conclude();
	end
endmodule // stp_serial_test_port_test
